/* mode_ctrl_defines.vh */
`ifndef MODE_CTRL_DEFINES_VH
`define MODE_CTRL_DEFINES_VH

// Field positions in the transmit mode-code descriptor control word.
`define CW_IRQ_ON_ACCESS 14
`define CW_IRQ_ON_BROADCAST 13
`define CW_FORCE_BUSY 12
`define CW_DESC_ACCESSED 11
`define CW_BUFFER_SELECTOR 10
`define CW_BROADCAST_RCVD 9
`define CW_PINGPONG_ACK 8
`define CW_STOP_PINGPONG 3
`define CW_PINGPONG_ENABLE 2

// Reset value after master reset.
`define CW_RESET_VALUE 16'h0000

// Host-writable bit masks: anytime, and only while execution is stopped.
`define CW_WMASK_ANYTIME 16'hF008
`define CW_WMASK_STOPPED 16'h0004

// Mode codes and addresses of interest.
`define MC_RESET_TERMINAL 5'h08
`define MC_FIRST_WITH_DATA 5'h10
`define RT_BROADCAST_ADDR 5'h1F

// Interrupt source codes in a log entry.
`define LOG_SRC_ACCESS 2'h1
`define LOG_SRC_BROADCAST 2'h2

`endif

/* mode_cmd_eval.v */
`timescale 1ns/1ps
`include "mode_ctrl_defines.vh"

module mode_cmd_eval
(
  // Command under evaluation
  input wire [4:0] cmd_mode_code,
  input wire [4:0] cmd_terminal_address,
  // Control word fields and configuration
  input wire force_busy,
  input wire global_busy,
  input wire broadcast_invalid_option,
  input wire pingpong_enable,
  input wire pingpong_acknowledge,
  // Decisions
  output wire cmd_is_broadcast,
  output wire cmd_accepted,
  output wire busy_reported,
  output wire mode_data_enable,
  output wire pingpong_active
);

  function is_broadcast;
    input [4:0] addr;
    begin
      is_broadcast = (addr == `RT_BROADCAST_ADDR);
    end
  endfunction

  wire reset_cmd;

  assign cmd_is_broadcast = is_broadcast(cmd_terminal_address);
  // Address 31 is not recognised at all while broadcast is declared invalid.
  assign cmd_accepted = !(is_broadcast(cmd_terminal_address) && broadcast_invalid_option);
  assign reset_cmd = (cmd_mode_code == `MC_RESET_TERMINAL);
  // The reset-terminal status must go out clean, so busy is suppressed for it.
  assign busy_reported = (force_busy || global_busy) && !reset_cmd;
  assign mode_data_enable = !(busy_reported && (cmd_mode_code >= `MC_FIRST_WITH_DATA));
  // Ping-pong only counts once the handshake has been acknowledged.
  assign pingpong_active = pingpong_enable && pingpong_acknowledge;

endmodule

/* rt_tx_mode_code_control_word.v */
// Function
// - Access interrupt posted after valid mode command.
// - Broadcast interrupt posted after valid broadcast command.
// - Broadcast-invalid option disables address 31 commands.
// - Force-busy bit sets Busy for this code.
// - Global busy setting also applies Busy status.
// - Busy blocks mode data and selector toggle.
// - Mode code 8 ignores force-busy bit.
// - Accessed flag set on message completion.
// - Accessed flag cleared by resets, host read.
// - Selector picks pointer A or B.
// - Selector is device-owned, host read-only.
// - Selector inverts after each error-free, non-busy ping-pong message, except illegal ones under selector_toggle_inhibit.
// - Selector cleared by master and software reset.
// - Selector ignored in indexed single-buffer mode.
// - Unacknowledged ping-pong uses single buffer, no toggle.
`timescale 1ns/1ps
`include "mode_ctrl_defines.vh"

module rt_tx_mode_code_control_word
(
  // Clock, master reset and software reset
  input wire clk,
  input wire resetn,
  input wire software_reset,
  // Host word access to the control word
  input wire host_wr_en,
  input wire host_rd_en,
  input wire [15:0] host_wdata,
  output wire [15:0] host_rdata,
  // Global configuration
  input wire exec_running,
  input wire irq_enable_access,
  input wire irq_enable_broadcast,
  input wire broadcast_invalid_option,
  input wire global_busy,
  input wire selector_toggle_inhibit,
  input wire pingpong_acknowledge,
  // Command and message events from the protocol engine
  input wire cmd_start,
  input wire [4:0] cmd_mode_code,
  input wire [4:0] cmd_terminal_address,
  input wire cmd_illegal,
  input wire msg_done,
  input wire msg_error,
  // Command response decisions
  output wire status_busy,
  output wire mode_data_enable,
  output wire use_pointer_b,
  output wire pingpong_mode,
  // Interrupt posting and log entry
  output wire irq_post,
  output wire [1:0] irq_source
);

  localparam ST_IDLE = 2'b01;
  localparam ST_MSG = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;

  reg [15:0] host_rdata_reg;
  reg irq_on_access_reg;
  reg irq_on_broadcast_reg;
  reg force_busy_reg;
  reg stop_pingpong_reg;
  reg pingpong_enable_reg;
  reg descriptor_accessed_flag_reg;
  reg descriptor_accessed_flag_next;
  reg buffer_selector_reg;
  reg buffer_selector_next;
  reg broadcast_rcvd_reg;
  reg broadcast_rcvd_next;

  reg busy_reg;
  reg data_enable_reg;
  reg use_b_reg;
  reg pingpong_reg;
  reg cmd_bcast_reg;
  reg cmd_illegal_reg;
  reg irq_post_reg;
  reg irq_post_next;
  reg [1:0] irq_source_reg;
  reg [1:0] irq_source_next;

  wire ev_bcast;
  wire ev_accepted;
  wire ev_busy;
  wire ev_data_enable;
  wire ev_pingpong;
  wire take_cmd;
  wire finish;
  wire toggle_ok;
  reg [15:0] word_now;

  function irq_owed;
    input illegal;
    input select_bit;
    input enable_bit;
    begin
      irq_owed = !illegal && select_bit && enable_bit;
    end
  endfunction

  mode_cmd_eval u_eval
  (
    .cmd_mode_code(cmd_mode_code),
    .cmd_terminal_address(cmd_terminal_address),
    .force_busy(force_busy_reg),
    .global_busy(global_busy),
    .broadcast_invalid_option(broadcast_invalid_option),
    .pingpong_enable(pingpong_enable_reg),
    .pingpong_acknowledge(pingpong_acknowledge),
    .cmd_is_broadcast(ev_bcast),
    .cmd_accepted(ev_accepted),
    .busy_reported(ev_busy),
    .mode_data_enable(ev_data_enable),
    .pingpong_active(ev_pingpong)
  );

  // A command dropped as invalid never opens a message.
  assign take_cmd = cmd_start && ev_accepted;
  assign finish = msg_done && (state_reg == ST_MSG);

  // Busy-ended and unacknowledged ping-pong messages keep the selector; illegal
  // commands keep it only when software asked for that.
  assign toggle_ok = pingpong_reg && !msg_error && !busy_reg
    && !(selector_toggle_inhibit && cmd_illegal_reg);

  always @*
  begin
    word_now = 16'h0000;
    word_now[`CW_IRQ_ON_ACCESS] = irq_on_access_reg;
    word_now[`CW_IRQ_ON_BROADCAST] = irq_on_broadcast_reg;
    word_now[`CW_FORCE_BUSY] = force_busy_reg;
    word_now[`CW_DESC_ACCESSED] = descriptor_accessed_flag_reg;
    word_now[`CW_BUFFER_SELECTOR] = buffer_selector_reg;
    word_now[`CW_BROADCAST_RCVD] = broadcast_rcvd_reg;
    word_now[`CW_PINGPONG_ACK] = pingpong_acknowledge;
    word_now[`CW_STOP_PINGPONG] = stop_pingpong_reg;
    word_now[`CW_PINGPONG_ENABLE] = pingpong_enable_reg;
  end

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (take_cmd)
        begin
          state_next = ST_MSG;
        end
      end
      ST_MSG:
      begin
        if (msg_done)
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @*
  begin
    descriptor_accessed_flag_next = descriptor_accessed_flag_reg;
    buffer_selector_next = buffer_selector_reg;
    broadcast_rcvd_next = broadcast_rcvd_reg;
    irq_post_next = 1'b0;
    irq_source_next = 2'h0;
    // A host read clears the flag, but a completion in the same cycle wins.
    if (host_rd_en)
    begin
      descriptor_accessed_flag_next = 1'b0;
    end
    if (finish)
    begin
      descriptor_accessed_flag_next = 1'b1;
      if (toggle_ok)
      begin
        buffer_selector_next = ~buffer_selector_reg;
      end
      if (cmd_bcast_reg)
      begin
        broadcast_rcvd_next = 1'b1;
      end
      if (irq_owed(cmd_illegal_reg, irq_on_access_reg, irq_enable_access))
      begin
        irq_post_next = 1'b1;
        irq_source_next = irq_source_next | `LOG_SRC_ACCESS;
      end
      if (irq_owed(cmd_illegal_reg, cmd_bcast_reg && irq_on_broadcast_reg, irq_enable_broadcast))
      begin
        irq_post_next = 1'b1;
        irq_source_next = irq_source_next | `LOG_SRC_BROADCAST;
      end
    end
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      host_rdata_reg <= `CW_RESET_VALUE;
      descriptor_accessed_flag_reg <= 1'b0;
      buffer_selector_reg <= 1'b0;
      broadcast_rcvd_reg <= 1'b0;
      busy_reg <= 1'b0;
      data_enable_reg <= 1'b1;
      use_b_reg <= 1'b0;
      pingpong_reg <= 1'b0;
      cmd_bcast_reg <= 1'b0;
      cmd_illegal_reg <= 1'b0;
      irq_post_reg <= 1'b0;
      irq_source_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      irq_post_reg <= irq_post_next;
      irq_source_reg <= irq_source_next;
      if (host_rd_en)
      begin
        host_rdata_reg <= word_now;
      end
      if (software_reset)
      begin
        descriptor_accessed_flag_reg <= 1'b0;
        buffer_selector_reg <= 1'b0;
        broadcast_rcvd_reg <= 1'b0;
      end
      else
      begin
        descriptor_accessed_flag_reg <= descriptor_accessed_flag_next;
        buffer_selector_reg <= buffer_selector_next;
        broadcast_rcvd_reg <= broadcast_rcvd_next;
      end
      // Decisions are frozen at command arrival so a mid-message host write
      // cannot change the status already sent.
      if (take_cmd && state_reg == ST_IDLE)
      begin
        busy_reg <= ev_busy;
        data_enable_reg <= ev_data_enable;
        pingpong_reg <= ev_pingpong;
        // Indexed mode never reads the selector, so its pointer is held at A.
        if (pingpong_enable_reg)
        begin
          use_b_reg <= buffer_selector_reg;
        end
        else
        begin
          use_b_reg <= 1'b0;
        end
        cmd_bcast_reg <= ev_bcast;
        cmd_illegal_reg <= cmd_illegal;
      end
    end
  end

  // Host-owned bits live apart so that device updates can never disturb them.
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      irq_on_access_reg <= 1'b0;
      irq_on_broadcast_reg <= 1'b0;
      force_busy_reg <= 1'b0;
      stop_pingpong_reg <= 1'b0;
      pingpong_enable_reg <= 1'b0;
    end
    else
    begin
      // Device-owned bits ignore host writes entirely.
      if (host_wr_en)
      begin
        irq_on_access_reg <= host_wdata[`CW_IRQ_ON_ACCESS];
        irq_on_broadcast_reg <= host_wdata[`CW_IRQ_ON_BROADCAST];
        force_busy_reg <= host_wdata[`CW_FORCE_BUSY];
        stop_pingpong_reg <= host_wdata[`CW_STOP_PINGPONG];
        if (!exec_running)
        begin
          pingpong_enable_reg <= host_wdata[`CW_PINGPONG_ENABLE];
        end
      end
    end
  end

  assign host_rdata = host_rdata_reg;
  assign status_busy = busy_reg;
  assign mode_data_enable = data_enable_reg;
  assign use_pointer_b = use_b_reg;
  assign pingpong_mode = pingpong_reg;
  assign irq_post = irq_post_reg;
  assign irq_source = irq_source_reg;

endmodule

/* rt_mode_props.sv */
`timescale 1ns/1ps
module rt_mode_props
(
  // Clock and resets
  input wire clk,
  input wire resetn,
  input wire software_reset,
  // Host and configuration
  input wire host_rd_en,
  input wire [15:0] host_rdata,
  input wire global_busy,
  input wire broadcast_invalid_option,
  input wire pingpong_acknowledge,
  // Command events
  input wire cmd_start,
  input wire [4:0] cmd_mode_code,
  input wire [4:0] cmd_terminal_address,
  input wire msg_done,
  // Decisions
  input wire status_busy,
  input wire mode_data_enable,
  input wire pingpong_mode,
  input wire irq_post,
  input wire [1:0] irq_source
);
  reg open_reg;
  wire bc_bad = cmd_terminal_address == 5'h1F && broadcast_invalid_option;
  wire acc = cmd_start && !open_reg && !bc_bad;
  // Shadow of the open message, so refused commands are told apart.
  always @(posedge clk)
  begin
    if (!resetn)
      open_reg <= 1'b0;
    else if (acc)
      open_reg <= 1'b1;
    else if (msg_done)
      open_reg <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_mc8; acc && cmd_mode_code == 5'h08 |=> !status_busy; endproperty
  a_mc8: assert property (p_mc8) else $error("busy on reset");
  property p_gbusy; acc && global_busy && cmd_mode_code != 5'h08 |=> status_busy; endproperty
  a_gbusy: assert property (p_gbusy) else $error("busy missing");
  property p_nodata; acc && global_busy && cmd_mode_code[4] |=> !mode_data_enable; endproperty
  a_nodata: assert property (p_nodata) else $error("data while busy");
  property p_bcinv; cmd_start && bc_bad |=> $stable({status_busy, pingpong_mode}); endproperty
  a_bcinv: assert property (p_bcinv) else $error("invalid broadcast taken");
  property p_single; acc && !pingpong_acknowledge |=> !pingpong_mode; endproperty
  a_single: assert property (p_single) else $error("ping-pong unacked");
  property p_irq; irq_post |-> $past(msg_done) && irq_source != 2'h0 ##1 !irq_post; endproperty
  a_irq: assert property (p_irq) else $error("stray interrupt");
  property p_rdclr; host_rd_en && !msg_done ##1 host_rd_en |=> !host_rdata[11]; endproperty
  a_rdclr: assert property (p_rdclr) else $error("flag kept");
  property p_swr; software_reset ##1 host_rd_en |=> host_rdata[11:9] == 3'h0; endproperty
  a_swr: assert property (p_swr) else $error("soft reset missed");
endmodule
bind rt_tx_mode_code_control_word rt_mode_props chk_i (.*);

/* bus_controller_model.sv */
`timescale 1ns/1ps
module bus_controller_model
(
  // Clock
  input wire clk,
  // Command and completion events
  output reg cmd_start,
  output reg [4:0] cmd_mode_code,
  output reg [4:0] cmd_terminal_address,
  output reg cmd_illegal,
  output reg msg_done,
  output reg msg_error
);
  initial
  begin
    {cmd_start, cmd_mode_code, cmd_terminal_address, cmd_illegal, msg_done, msg_error} = 14'h0;
  end
  // Qualifiers are inverted once their strobe drops, so stale values are never trusted.
  task send(input [4:0] code, input [4:0] addr, input ill, input err, input integer gap);
  begin
    @(posedge clk);
    cmd_start <= 1'b1;
    cmd_mode_code <= code;
    cmd_terminal_address <= addr;
    cmd_illegal <= ill;
    @(posedge clk);
    cmd_start <= 1'b0;
    cmd_mode_code <= ~code;
    cmd_terminal_address <= ~addr;
    cmd_illegal <= ~ill;
    repeat (gap) @(posedge clk);
    msg_done <= 1'b1;
    msg_error <= err;
    @(posedge clk);
    msg_done <= 1'b0;
    msg_error <= ~err;
    // Return just after the closing edge, once the completion pulse has settled.
    #1;
  end
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  reg clk, resetn, software_reset, host_wr_en, host_rd_en, exec_running, irq_enable_access;
  reg irq_enable_broadcast, broadcast_invalid_option, global_busy;
  reg selector_toggle_inhibit, pingpong_acknowledge, sel;
  reg [15:0] host_wdata;
  wire [15:0] host_rdata;
  wire cmd_start, cmd_illegal, msg_done, msg_error, status_busy, mode_data_enable;
  wire use_pointer_b, pingpong_mode, irq_post;
  wire [4:0] cmd_mode_code, cmd_terminal_address;
  wire [1:0] irq_source;
  integer miscompares = 0;
  integer n_compared = 0;
  rt_tx_mode_code_control_word DUT (.*);
  bus_controller_model bc (.*);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [15:0] d);
  begin
    @(posedge clk);
    host_wr_en <= 1'b1;
    host_wdata <= d;
    @(posedge clk);
    host_wr_en <= 1'b0;
  end
  endtask
  task rd(input integer n);
  begin
    @(posedge clk);
    host_rd_en <= 1'b1;
    repeat (n) @(posedge clk);
    host_rd_en <= 1'b0;
    #1;
  end
  endtask
  task pp(input ill, input err, input bsy);
  begin
    @(posedge clk);
    global_busy <= bsy;
    bc.send(5'h11, 5'h05, ill, err, 1);
    chk(pingpong_mode, 1'b1);
    chk(use_pointer_b, sel);
    chk(status_busy, bsy);
    if (bsy)
      chk(mode_data_enable, 1'b0);
    if (!ill && !err && !bsy)
      sel = ~sel;
    rd(1);
    chk(host_rdata[10], sel);
  end
  endtask
  task t_reset;
  begin
    rd(1);
    chk(host_rdata, 16'h0000);
    chk(mode_data_enable, 1'b1);
  end
  endtask
  task t_irq;
  begin
    wr(16'h6004);
    exec_running <= 1'b1;
    irq_enable_access <= 1'b1;
    bc.send(5'h02, 5'h05, 1'b0, 1'b0, 0);
    chk({irq_post, irq_source}, 3'h5);
    @(posedge clk);
    irq_enable_broadcast <= 1'b1;
    bc.send(5'h02, 5'h1F, 1'b0, 1'b0, 3);
    chk({irq_post, irq_source}, 3'h7);
    @(posedge clk);
    broadcast_invalid_option <= 1'b1;
    bc.send(5'h02, 5'h1F, 1'b0, 1'b0, 0);
    chk(irq_post, 1'b0);
    @(posedge clk);
    broadcast_invalid_option <= 1'b0;
    bc.send(5'h02, 5'h05, 1'b1, 1'b0, 0);
    chk(irq_post, 1'b0);
  end
  endtask
  task t_select;
  begin
    chk({pingpong_mode, use_pointer_b}, 2'h0);
    @(posedge clk);
    pingpong_acknowledge <= 1'b1;
    selector_toggle_inhibit <= 1'b1;
    sel = 1'b0;
    pp(1'b0, 1'b0, 1'b0);
    pp(1'b0, 1'b0, 1'b0);
    pp(1'b0, 1'b1, 1'b0);
    pp(1'b1, 1'b0, 1'b0);
    pp(1'b0, 1'b0, 1'b1);
    pp(1'b0, 1'b0, 1'b0);
  end
  endtask
  task t_busy;
  begin
    wr(16'h7000);
    bc.send(5'h11, 5'h05, 1'b0, 1'b0, 0);
    chk({status_busy, mode_data_enable, use_pointer_b}, {2'b10, sel});
    bc.send(5'h08, 5'h05, 1'b0, 1'b0, 0);
    chk(status_busy, 1'b0);
    sel = ~sel;
    wr(16'h0F00);
    rd(1);
    chk(host_rdata[11:8], {1'b1, sel, 2'h3});
    rd(2);
    chk(host_rdata[11], 1'b0);
    pp(1'b0, 1'b0, 1'b0);
    @(posedge clk);
    software_reset <= 1'b1;
    @(posedge clk);
    software_reset <= 1'b0;
    host_rd_en <= 1'b1;
    @(posedge clk);
    host_rd_en <= 1'b0;
    #1;
    chk(host_rdata, 16'h0104);
    bc.send(5'h11, 5'h05, 1'b0, 1'b0, 0);
    chk(use_pointer_b, 1'b0);
  end
  endtask
  task stop_test;
  begin
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  initial
  begin
    {resetn, software_reset, host_wr_en, host_rd_en, exec_running, irq_enable_access} = 6'h0;
    {irq_enable_broadcast, broadcast_invalid_option, global_busy, sel} = 4'h0;
    {selector_toggle_inhibit, pingpong_acknowledge, host_wdata} = 18'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_irq;
    t_select;
    t_busy;
    stop_test;
  end
  // The whole run needs about 115 cycles, so this only trips on a hang.
  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares = miscompares + 1;
    stop_test;
  end
endmodule
